// file: dct_call.sv
// per-output call timer: delay, extend, delay/extend
`timescale 1ns/1ps
module dct_call
   import dct_pkg::*;
(
   // clock and reset
   input  wire logic     mclk,
   input  wire logic     rst_b,
   // timing
   input  wire logic     tick,
   input  wire logic     det,
   input  wire logic     green,
   input  wire logic     exempt,
   input  wire dct_cfg_t cfg,
   output logic          call
);

   typedef enum {S_IDLE, S_DELAY, S_ON, S_EXT} dct_cst_t;
   dct_cst_t      st_q, st_d;
   logic [TW-1:0] cnt_q, cnt_d;
   logic          inhibit;

   // next state of the call timer
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      inhibit = (cfg.mode == M_NORMAL_DELAY) & green & ~exempt;
      unique case (st_q)
         S_IDLE: begin
            cnt_d = '0;
            if (det) begin
               st_d = (cfg.mode == M_EXTEND) ? S_ON : S_DELAY;
            end
         end
         S_DELAY: begin
            // delay runs regardless of phase unless inhibited
            if (!det) begin
               st_d = S_IDLE;
            end else if (cnt_q >= cfg.dly) begin
               st_d  = S_ON;  // accept only with presence still there
               cnt_d = '0;
            end else if (tick && !inhibit) begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         S_ON: begin
            cnt_d = '0;
            if (!det) begin
               st_d = (cfg.mode == M_EXTEND || cfg.mode == M_DELAY_EXTEND) ? S_EXT : S_IDLE;
            end
         end
         S_EXT: begin
            if (det) begin
               st_d  = S_ON;  // re-entry holds call and restarts extend
               cnt_d = '0;
            end else if (cnt_q >= cfg.ext) begin
               st_d  = S_IDLE;  // drop; in delay/extend a fresh delay is needed next time
               cnt_d = '0;
            end else if (tick) begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      endcase
   end

   // registers
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st_q  <= S_IDLE;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign call = (st_q == S_ON) | (st_q == S_EXT);

   a_ext_drop: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_q == S_EXT && !det && cnt_q >= cfg.ext) |=> !call)
      else $error("extend did not drop");
   a_reentry_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_q == S_EXT && det) |=> (call && cnt_q == '0))
      else $error("re-entry did not hold call");
   a_delay_inhib: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_q == S_DELAY && st_d == S_DELAY && inhibit) |=> $stable(cnt_q))
      else $error("delay ran while inhibited");
   a_accept_pres: assert property (@(posedge mclk) disable iff (!rst_b)
      (cfg.mode == M_DELAY_EXTEND && $rose(call)) |-> $past(det))
      else $error("call accepted without presence");
   a_fresh_delay: assert property (@(posedge mclk) disable iff (!rst_b)
      (cfg.mode == M_DELAY_EXTEND && $fell(call) && cfg.dly != '0) |=> !call[*2])
      else $error("call re-accepted without delay");
   c_ext_reentry: cover property (@(posedge mclk) st_q == S_EXT ##1 st_q == S_ON);
   c_delay_done: cover property (@(posedge mclk) st_q == S_DELAY ##1 st_q == S_ON);

endmodule

// file: dct_ctl_model.sv
// controller side model: phase green outputs seen by the call timers
`timescale 1ns/1ps
module dct_ctl_model
   import dct_pkg::*;
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // bench request and phase outputs
   input  wire logic [NCALL-1:0] green_req,
   output logic      [NCALL-1:0] phase_green
);
   // ************************************************************
   // phase greens
   // ************************************************************
   // greens move only on clock edges, like a real controller's phase outputs
   always_ff @(posedge mclk) begin
      phase_green <= rst_b ? green_req : '0;
   end
endmodule

// file: dct_pkg.sv
// shared constants and types for detector call timing
package dct_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NZONE  = 8;
   localparam int NCALL  = 8;
   localparam int TW     = 8;  // timer width in bits

   // ************************************************************
   // time base: one tick per 100 ms
   // ************************************************************
   localparam int CLK_MHZ    = 100;
   localparam int TICK_MS    = 100;
   localparam int TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
   localparam int RESP_MS    = 112;
   localparam int RESP_CYC   = RESP_MS * 1000 * CLK_MHZ;
   localparam int PULSE_US   = 125000;  // pulse call width
   localparam int PULSE_CYC  = PULSE_US * CLK_MHZ;

   // ************************************************************
   // register map (plain port, index = address)
   // ************************************************************
   localparam logic [4:0] A_CFG0   = 5'h00;  // 8 call configs at 0x00..0x07
   localparam logic [4:0] A_ZFN0   = 5'h08;  // 8 zone functions at 0x08..0x0f
   localparam logic [4:0] A_STAT   = 5'h10;  // call state
   localparam logic [4:0] A_CTRL   = 5'h11;  // bit0: exempt controller type
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam int CFG_DLY_LSB = 0;
   localparam int CFG_EXT_LSB = 8;
   localparam int CFG_MOD_LSB = 16;
   localparam int CFG_ZON_LSB = 18;

   typedef enum logic [1:0] {
      M_FULL_DELAY, M_NORMAL_DELAY, M_EXTEND, M_DELAY_EXTEND
   } dct_mode_t;

   typedef enum logic [1:0] {
      Z_PRESENCE, Z_DIR_PRESENCE, Z_PULSE, Z_DIR_PULSE
   } dct_zfn_t;

   typedef struct packed {
      logic [2:0] zone;
      dct_mode_t  mode;
      logic [TW-1:0] ext;
      logic [TW-1:0] dly;
   } dct_cfg_t;

endpackage

// file: dct_top.sv
// detector call timing: zone shaping, call timers and register port
// Function
// - full-time delay timer runs regardless of phase; call after delay.
// - normal delay holds timer while assigned phase green, unless exempt type.
// - extend keeps call asserted for extend time after vehicle leaves.
// - delay/extend accepts call only after delay expires with presence.
// - delay/extend holds call until empty and extend expired.
// - re-entry during extend keeps call and restarts extend from zero.
// - after extend drop a fresh full delay is needed.
// - each zone is presence, directional presence, pulse or directional pulse.
// - at least eight independent detection zones.
// - at least eight call outputs.
// - overlapping zones evaluated independently.
// - call appears within 112 ms of arrival, apart from delay.
// - camera failure or power loss forces constant calls on affected outputs.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module dct_top
   import dct_pkg::*;
#(
   parameter int TICK_CYCLES  = TICK_CYC,
   parameter int PULSE_CYCLES = PULSE_CYC
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // register port
   input  wire logic [4:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata,
   // detection side
   input  wire logic [NZONE-1:0] zone_raw,
   input  wire logic [NZONE-1:0] zone_dir_ok,
   input  wire logic [NCALL-1:0] phase_green,
   input  wire logic             cam_fail,
   // controller side
   output logic      [NCALL-1:0] call_out
);

   // ************************************************************
   // register file
   // ************************************************************
   dct_cfg_t        cfg_q [NCALL];
   dct_cfg_t        cfg_d [NCALL];
   dct_zfn_t        zfn_q [NZONE];
   dct_zfn_t        zfn_d [NZONE];
   logic            exempt_q, exempt_d;
   logic [31:0]     rdata_q, rdata_d;
   logic [NCALL-1:0] call_int;
   logic [NCALL-1:0] out_q, out_d;

   // write decode and read mux; unmapped reads give zero
   always_comb begin
      for (int i = 0; i < NCALL; i++) begin
         cfg_d[i] = cfg_q[i];
         if (reg_wr && reg_addr == A_CFG0 + 5'(i)) begin
            cfg_d[i] = dct_cfg_t'(reg_wdata[20:0]);
         end
      end
      for (int i = 0; i < NZONE; i++) begin
         zfn_d[i] = zfn_q[i];
         if (reg_wr && reg_addr == A_ZFN0 + 5'(i)) begin
            zfn_d[i] = dct_zfn_t'(reg_wdata[1:0]);
         end
      end
      exempt_d = exempt_q;
      if (reg_wr && reg_addr == A_CTRL) begin
         exempt_d = reg_wdata[0];
      end
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         if (reg_addr < A_ZFN0) begin
            rdata_d = {11'h000, cfg_q[reg_addr[2:0]]};
         end else if (reg_addr < A_STAT) begin
            rdata_d = {30'h0000_0000, zfn_q[reg_addr[2:0]]};
         end else if (reg_addr == A_STAT) begin
            rdata_d = {23'h000000, cam_fail, out_q};
         end else if (reg_addr == A_CTRL) begin
            rdata_d = {31'h0000_0000, exempt_q};
         end
      end
   end

   // register file flops
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < NCALL; i++) begin
            cfg_q[i] <= dct_cfg_t'(CFG_RST[20:0]);
         end
         for (int i = 0; i < NZONE; i++) begin
            zfn_q[i] <= Z_PRESENCE;
         end
         exempt_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         cfg_q    <= cfg_d;
         zfn_q    <= zfn_d;
         exempt_q <= exempt_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ************************************************************
   // common time base
   // ************************************************************
   logic [23:0] tcnt_q, tcnt_d;
   logic        tick_q, tick_d;

   // one tick per period shared by all call timers
   always_comb begin
      tick_d = (tcnt_q == 24'(TICK_CYCLES - 1));
      tcnt_d = tick_d ? 24'h000000 : tcnt_q + 24'h000001;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tcnt_q <= 24'h000000;
         tick_q <= 1'b0;
      end else begin
         tcnt_q <= tcnt_d;
         tick_q <= tick_d;
      end
   end

   // ************************************************************
   // zones and calls
   // ************************************************************
   logic [NZONE-1:0] det;

   // each zone shaped on its own, so overlapping zones all fire
   // each output has its own timer on a selectable zone
   for (genvar g = 0; g < NZONE; g++) begin : g_ch
      dct_zone #(
         .PULSE_CYCLES (PULSE_CYCLES)
      ) u_zone (
         .mclk   (mclk),
         .rst_b  (rst_b),
         .raw    (zone_raw[g]),
         .dir_ok (zone_dir_ok[g]),
         .fn     (zfn_q[g]),
         .det    (det[g])
      );
      dct_call u_call (
         .mclk   (mclk),
         .rst_b  (rst_b),
         .tick   (tick_q),
         .det    (det[cfg_q[g].zone]),
         .green  (phase_green[g]),
         .exempt (exempt_q),
         .cfg    (cfg_q[g]),
         .call   (call_int[g])
      );
   end

   // output stage: fail-safe forces every call on
   // latency is a few cycles, far inside the response limit
   always_comb begin
      out_d = cam_fail ? {NCALL{1'b1}} : call_int;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         out_q <= {NCALL{1'b1}};  // calls held on while in reset
      end else begin
         out_q <= out_d;
      end
   end

   assign call_out = out_q;

   // ************************************************************
   // checks
   // ************************************************************
   a_fail_safe: assert property (@(posedge mclk) disable iff (!rst_b)
      cam_fail |=> (call_out == {NCALL{1'b1}}))
      else $error("fail-safe not forcing calls");
   a_fast_resp: assert property (@(posedge mclk) disable iff (!rst_b)
      ($rose(zone_raw[0]) && zfn_q[0] == Z_PRESENCE && cfg_q[0].zone == 3'h0
       && cfg_q[0].mode == M_EXTEND) |-> ##[1:6] call_out[0])
      else $error("call too slow");
   a_tick_period: assert property (@(posedge mclk) disable iff (!rst_b)
      tick_q |=> !tick_q)
      else $error("tick too wide");
   c_fail: cover property (@(posedge mclk) cam_fail ##1 !cam_fail);
   c_call: cover property (@(posedge mclk) $rose(call_out[0]));

endmodule

// file: dct_top_bench.sv
// self-checking bench for the detector call timing block
`timescale 1ns/1ps
module dct_top_bench;
   import dct_pkg::*;
   logic             mclk, rst_b, reg_wr, reg_rd, cam_fail;
   logic [4:0]       reg_addr;
   logic [31:0]      reg_wdata, reg_rdata;
   logic [NZONE-1:0] zone_raw, zone_dir_ok;
   logic [NCALL-1:0] phase_green, green_req, call_out;
   int               error_cnt, cmp_count;

   // short counts keep the run small: 10 cycles a tick, 5 cycle pulses
   dct_top #(.TICK_CYCLES(10), .PULSE_CYCLES(5)) i_dut (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .zone_raw(zone_raw), .zone_dir_ok(zone_dir_ok), .phase_green(phase_green),
      .cam_fail(cam_fail), .call_out(call_out));
   dct_ctl_model i_ctl (.mclk(mclk), .rst_b(rst_b), .green_req(green_req),
      .phase_green(phase_green));

   // ************************************************************
   // helpers
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   function automatic logic [31:0] cfgw(int z, int m, int e, int d);
      return {11'h000, 3'(z), 2'(m), 8'(e), 8'(d)};
   endfunction
   task automatic raw(input int z, input logic v);
      @(posedge mclk);
      zone_raw[z] <= v;
   endtask
   // bounded wait for a call level; running out ends the run
   task automatic wait_call(input int i, input logic v, input int n);
      int k;
      for (k = 0; k < n && call_out[i] !== v; k++) @(posedge mclk) #1;
      chk(32'(call_out[i]), 32'(v));
      if (call_out[i] !== v) give_verdict();
   endtask
   task automatic hold(input int i, input logic v, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge mclk) #1;
         if (call_out[i] !== v) ok = 1'b0;
      end
      chk(32'(ok), 32'h1);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs();
      rd(A_CFG0, CFG_RST);
      wr(A_CFG0 + 5'h01, cfgw(1, 0, 0, 3));
      rd(A_CFG0 + 5'h01, cfgw(1, 0, 0, 3));
      wr(5'h12, 32'hffff_ffff);
      rd(5'h12, 32'h0);
      rd(A_STAT, 32'h0);
      $display("test regs done");
   endtask
   // full delay with green on; the same zone 1 also feeds a second call, call 5
   task automatic t_full();
      green_req[1] <= 1'b1;
      wr(A_CFG0 + 5'h05, cfgw(1, 2, 0, 0));
      raw(1, 1'b1);
      wait_call(5, 1'b1, 5);
      hold(1, 1'b0, 15);
      wait_call(1, 1'b1, 40);
      raw(1, 1'b0);
      wait_call(1, 1'b0, 5);
      green_req[1] <= 1'b0;
      $display("test full delay done");
   endtask
   task automatic t_normal();
      wr(A_CFG0 + 5'h02, cfgw(2, 1, 0, 2));
      green_req[2] <= 1'b1;
      raw(2, 1'b1);
      hold(2, 1'b0, 40);
      green_req[2] <= 1'b0;
      wait_call(2, 1'b1, 35);
      raw(2, 1'b0);
      wait_call(2, 1'b0, 5);
      wr(A_CTRL, 32'h1);
      rd(A_CTRL, 32'h1);
      green_req[2] <= 1'b1;
      raw(2, 1'b1);
      wait_call(2, 1'b1, 35);
      raw(2, 1'b0);
      wr(A_CTRL, 32'h0);
      green_req[2] <= 1'b0;
      $display("test normal delay done");
   endtask
   task automatic t_extend();
      wr(A_CFG0, cfgw(0, 2, 2, 0));
      raw(0, 1'b1);
      wait_call(0, 1'b1, 5);
      raw(0, 1'b0);
      hold(0, 1'b1, 8);
      wait_call(0, 1'b0, 30);
      $display("test extend done");
   endtask
   task automatic t_dlyext();
      wr(A_CFG0 + 5'h03, cfgw(3, 3, 3, 2));
      raw(3, 1'b1);
      hold(3, 1'b0, 8);
      wait_call(3, 1'b1, 35);
      raw(3, 1'b0);
      hold(3, 1'b1, 5);
      raw(3, 1'b1);
      hold(3, 1'b1, 20);
      raw(3, 1'b0);
      hold(3, 1'b1, 15);
      wait_call(3, 1'b0, 45);
      raw(3, 1'b1);
      hold(3, 1'b0, 8);
      wait_call(3, 1'b1, 35);
      raw(3, 1'b0);
      $display("test delay extend done");
   endtask
   // every zone function, with and without a valid direction
   task automatic t_zfn();
      int f, d;
      wr(A_CFG0 + 5'h04, cfgw(4, 0, 0, 0));
      for (f = 0; f < 4; f++) begin
         wr(A_ZFN0 + 5'h04, 32'(f));
         for (d = 0; d < 2; d++) begin
            zone_dir_ok[4] <= d[0];
            raw(4, 1'b1);
            if (f == 0 || f == 2 || d == 1) wait_call(4, 1'b1, 6);
            else hold(4, 1'b0, 6);
            repeat (10) @(posedge mclk);
            #1 chk(32'(call_out[4]), 32'(f < 2 && (f == 0 || d == 1)));
            raw(4, 1'b0);
            repeat (6) @(posedge mclk);
         end
      end
      $display("test zone functions done");
   endtask
   task automatic t_fail();
      cam_fail <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(32'(call_out), 32'hff);
      rd(A_STAT, 32'h1ff);
      cam_fail <= 1'b0;
      wait_call(0, 1'b0, 5);
      $display("test camera failure done");
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00;
      reg_wdata = 32'h0; zone_raw = '0; zone_dir_ok = '0; cam_fail = 1'b0;
      green_req = '0; error_cnt = 0; cmp_count = 0;
      repeat (8) @(posedge mclk);
      #1 chk(32'(call_out), 32'hff);
      @(posedge mclk) rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk(32'(call_out), 32'h0);
      t_regs();
      t_full();
      t_normal();
      t_extend();
      t_dlyext();
      t_zfn();
      t_fail();
      give_verdict();
   end
endmodule

// file: dct_zone.sv
// per-zone function shaping: presence or entry pulse
`timescale 1ns/1ps
module dct_zone
   import dct_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC
) (
   // clock and reset
   input  wire logic     mclk,
   input  wire logic     rst_b,
   // detection
   input  wire logic     raw,
   input  wire logic     dir_ok,
   input  wire dct_zfn_t fn,
   output logic          det
);

   logic        prev_q, prev_d;
   logic [23:0] pcnt_q, pcnt_d;
   logic        det_q, det_d;
   logic        qual;

   // next state: direction gate then presence or pulse
   always_comb begin
      qual   = raw & ((fn == Z_PRESENCE) | (fn == Z_PULSE) | dir_ok);
      prev_d = qual;
      pcnt_d = pcnt_q;
      if (qual && !prev_q) begin
         pcnt_d = 24'(PULSE_CYCLES);
      end else if (pcnt_q != 24'h000000) begin
         pcnt_d = pcnt_q - 24'h000001;
      end
      unique case (fn)
         Z_PRESENCE, Z_DIR_PRESENCE: det_d = qual;
         Z_PULSE, Z_DIR_PULSE:       det_d = (pcnt_d != 24'h000000);
      endcase
   end

   // registers
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prev_q <= 1'b0;
         pcnt_q <= 24'h000000;
         det_q  <= 1'b0;
      end else begin
         prev_q <= prev_d;
         pcnt_q <= pcnt_d;
         det_q  <= det_d;
      end
   end

   assign det = det_q;

endmodule
